// [design/modbus_port_pkg.sv]
// shared constants, types and helpers of the serial port configuration block
package modbus_port_pkg;
  localparam int NUM_PORTS = 2;
  localparam int CLK_HZ = 25000000;
  localparam int CLK_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int CNT_W = 16;
  localparam int DIV_W = 18;
  localparam int CUST_UNIT_BPS = 100;

  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hfe;
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [3:0] BAUD_RST = 4'h3;
  localparam logic [3:0] BAUD_CUSTOM = 4'h8;
  localparam logic [12:0] CUST_MIN = 13'h0001;
  localparam logic [12:0] CUST_MAX = 13'h1388;
  localparam logic [12:0] CUST_RST = 13'h0060;
  localparam logic [11:0] MS_MAX = 12'hbb8;
  localparam logic [11:0] DELAY_RST = 12'h000;
  localparam logic [11:0] TMO_RST = 12'h0c8;

  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CUST = 8'h04;
  localparam logic [7:0] OFS_DELAY = 8'h08;
  localparam logic [7:0] OFS_TMO = 8'h0c;
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_MASK = 8'h24;
  localparam logic [7:0] OFS_STATE = 8'h28;

  localparam int EV_ACC = 0;
  localparam int EV_DIS = 1;
  localparam int EV_REPLY = 2;
  localparam int EV_TMO = 3;
  localparam int EV_W = 4;
  localparam int ST_W = EV_W * NUM_PORTS;

  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} parity_t;

  typedef struct packed {
    logic       startPowerOn;
    logic       masterMode;
    logic       rtuMode;
    logic       twoStop;
    parity_t    parity;
    logic       eightBits;
    logic [3:0] baudSel;
    logic [7:0] stationAddr;
  } port_cfg_t;

  localparam port_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, PAR_EVEN, 1'b0,
                                    BAUD_RST, ADDR_RST};

  typedef struct packed {
    logic       frameValid;
    logic [7:0] frameAddr;
    logic       frameEnd;
    logic       reqSent;
    logic       replyDone;
  } port_in_t;

  typedef struct packed {
    logic active;
    logic accepted;
    logic discarded;
    logic replyGo;
    logic rxTimeout;
    logic baudTick;
  } port_out_t;

  // clock cycles per bit for a rate selection
  function automatic logic [DIV_W-1:0] baudDiv(input logic [3:0] sel,
                                               input logic [12:0] cust);
    int d;
    case (sel)
      4'h0: d = CLK_HZ / 1200;
      4'h1: d = CLK_HZ / 2400;
      4'h2: d = CLK_HZ / 4800;
      4'h3: d = CLK_HZ / 9600;
      4'h4: d = CLK_HZ / 19200;
      4'h5: d = CLK_HZ / 38400;
      4'h6: d = CLK_HZ / 57600;
      4'h7: d = CLK_HZ / 115200;
      4'h8: d = CLK_HZ / (int'(cust) * CUST_UNIT_BPS);
      default: d = CLK_HZ / 9600;
    endcase
    return DIV_W'(d);
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) r[8*i +: 8] = data[8*i +: 8];
    return r;
  endfunction
endpackage

// [design/serial_port_ctrl.sv]
// per-port addressing, start gating, reply delay and receive timeout
`timescale 1ns/1ps
module serial_port_ctrl
  import modbus_port_pkg::*;
#(
  parameter int MsCycles = MS_CYCLES
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // settings
  input  wire modbus_port_pkg::port_cfg_t cfg,
  input  wire logic [11:0]                delayMs,
  input  wire logic [11:0]                tmoMs,
  input  wire logic                       runLevel,
  // traffic
  input  wire modbus_port_pkg::port_in_t  pin,
  output logic                            active,
  output logic                            accepted,
  output logic                            discarded,
  output logic                            replyGo,
  output logic                            rxTimeout
);
  import modbus_port_pkg::*;

  logic             runSeen, next_runSeen, started, next_started;
  logic             owed, next_owed, dlyRun, next_dlyRun, tmoRun, next_tmoRun;
  logic [11:0]      dlyCnt, next_dlyCnt, tmoCnt, next_tmoCnt;
  logic [CNT_W-1:0] dlyPre, next_dlyPre, tmoPre, next_tmoPre;
  logic             next_accepted, next_discarded, next_replyGo, next_rxTimeout;
  logic             hit, bcast;

  assign active = cfg.startPowerOn | started;
  assign bcast = pin.frameAddr == ADDR_BCAST;
  assign hit = cfg.masterMode | bcast | (pin.frameAddr == cfg.stationAddr);

  always_comb
  begin
    next_runSeen = runLevel;
    next_started = started;
    if (runLevel & ~runSeen) next_started = 1'b1;
    if (~runLevel) next_started = 1'b0;
    next_accepted = pin.frameValid & active & hit;
    next_discarded = pin.frameValid & active & ~hit;
    next_owed = owed;
    if (next_accepted) next_owed = ~cfg.masterMode & ~bcast;
    if (next_discarded) next_owed = 1'b0;
    next_dlyRun = dlyRun;
    next_dlyCnt = dlyCnt;
    next_dlyPre = dlyPre;
    next_replyGo = 1'b0;
    if (pin.frameEnd & owed & active)
    begin
      next_owed = 1'b0;
      next_dlyRun = 1'b1;
      next_dlyCnt = delayMs;
      next_dlyPre = '0;
    end
    else if (dlyRun)
    begin
      if (dlyCnt == 12'h000)
      begin
        next_dlyRun = 1'b0;
        next_replyGo = 1'b1;
      end
      else if (dlyPre == CNT_W'(MsCycles - 1))
      begin
        next_dlyPre = '0;
        next_dlyCnt = dlyCnt - 12'h001;
      end
      else next_dlyPre = dlyPre + 1'b1;
    end
    next_tmoRun = tmoRun;
    next_tmoCnt = tmoCnt;
    next_tmoPre = tmoPre;
    next_rxTimeout = 1'b0;
    if (pin.reqSent & cfg.masterMode & active & (tmoMs != 12'h000))
    begin
      next_tmoRun = 1'b1;
      next_tmoCnt = tmoMs;
      next_tmoPre = '0;
    end
    else if (pin.replyDone | ~active) next_tmoRun = 1'b0;
    else if (tmoRun)
    begin
      if (tmoPre == CNT_W'(MsCycles - 1))
      begin
        next_tmoPre = '0;
        next_tmoCnt = tmoCnt - 12'h001;
        if (tmoCnt == 12'h001)
        begin
          next_tmoRun = 1'b0;
          next_rxTimeout = 1'b1;
        end
      end
      else next_tmoPre = tmoPre + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      runSeen <= 1'b1;
      started <= 1'b0;
      owed <= 1'b0;
      dlyRun <= 1'b0;
      dlyCnt <= '0;
      dlyPre <= '0;
      tmoRun <= 1'b0;
      tmoCnt <= '0;
      tmoPre <= '0;
      accepted <= 1'b0;
      discarded <= 1'b0;
      replyGo <= 1'b0;
      rxTimeout <= 1'b0;
    end
    else if (ce)
    begin
      runSeen <= next_runSeen;
      started <= next_started;
      owed <= next_owed;
      dlyRun <= next_dlyRun;
      dlyCnt <= next_dlyCnt;
      dlyPre <= next_dlyPre;
      tmoRun <= next_tmoRun;
      tmoCnt <= next_tmoCnt;
      tmoPre <= next_tmoPre;
      accepted <= next_accepted;
      discarded <= next_discarded;
      replyGo <= next_replyGo;
      rxTimeout <= next_rxTimeout;
    end
  end
endmodule

// [design/modbus_serial_port_config.sv]
// two-port serial station configuration with register slave and interrupt
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module modbus_serial_port_config
  import modbus_port_pkg::*;
#(
  parameter int MsCycles = MS_CYCLES
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      ce,
  // register bus write
  input  wire logic [7:0]                awaddr,
  input  wire logic [2:0]                awprot,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // register bus read
  input  wire logic [7:0]                araddr,
  input  wire logic [2:0]                arprot,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // controller run state pin
  input  wire logic                      runPin,
  // port traffic and settings
  input  wire modbus_port_pkg::port_in_t  portIn [NUM_PORTS],
  output modbus_port_pkg::port_out_t      portOut [NUM_PORTS],
  output modbus_port_pkg::port_cfg_t      portCfg [NUM_PORTS],
  // interrupt
  output logic                           irq
);
  import modbus_port_pkg::*;

  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  // run pin filter
  logic [2:0] runSync, next_runSync;
  logic       runLevel, next_runLevel;

  // register file
  port_cfg_t   cfg [NUM_PORTS];
  port_cfg_t   next_cfg [NUM_PORTS];
  logic [12:0] cust [NUM_PORTS];
  logic [12:0] next_cust [NUM_PORTS];
  logic [11:0] dly [NUM_PORTS];
  logic [11:0] next_dly [NUM_PORTS];
  logic [11:0] tmo [NUM_PORTS];
  logic [11:0] next_tmo [NUM_PORTS];
  logic [ST_W-1:0] status, next_status, mask, next_mask, events;
  logic        next_irq;

  // bus state
  logic        wrGo, rdGo;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // bit-rate timing
  logic [DIV_W-1:0] baudCnt [NUM_PORTS];
  logic [DIV_W-1:0] next_baudCnt [NUM_PORTS];
  logic [DIV_W-1:0] div [NUM_PORTS];
  logic [NUM_PORTS-1:0] tick, next_tick;

  // per-port engines
  logic [NUM_PORTS-1:0] active, accepted, discarded, replyGo, rxTimeout;

  assign wrGo = awvalid & wvalid & ~bvalid;
  assign rdGo = arvalid & ~rvalid;
  assign awready = wrGo;
  assign wready = wrGo;
  assign arready = rdGo;

  // three-stage run pin filter
  always_comb
  begin
    next_runSync = {runSync[1:0], runPin};
    next_runLevel = runLevel;
    if (runSync[1] == runSync[2]) next_runLevel = runSync[2];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      runSync <= '0;
      runLevel <= 1'b0;
    end
    else if (ce)
    begin
      runSync <= next_runSync;
      runLevel <= next_runLevel;
    end
  end

  // register writes and event capture
  always_comb
  begin
    logic [31:0] merged;
    logic [7:0]  ofs;
    logic        ok;
    int          p;
    merged = '0;
    ofs = '0;
    ok = 1'b0;
    p = 0;
    next_cfg = cfg;
    next_cust = cust;
    next_dly = dly;
    next_tmo = tmo;
    next_mask = mask;
    next_status = status | events;
    next_bvalid = bvalid & ~bready;
    next_bresp = bresp;
    if (wrGo)
    begin
      ofs = {awaddr[7:2], 2'b00};
      next_bvalid = 1'b1;
      if (ofs < OFS_STATUS)
      begin
        p = int'(ofs[7:4]);
        ofs = {4'h0, ofs[3:0]};
        case (ofs)
          OFS_CFG:
          begin
            merged = mergeBytes(32'(cfg[p]), wdata, wstrb);
            ok = merged[7:0] >= ADDR_MIN && merged[7:0] <= ADDR_MAX
                 && merged[11:8] <= BAUD_CUSTOM
                 && merged[14:13] != 2'b11;
            if (ok) next_cfg[p] = port_cfg_t'(merged[$bits(port_cfg_t)-1:0]);
          end
          OFS_CUST:
          begin
            merged = mergeBytes(32'(cust[p]), wdata, wstrb);
            ok = merged[12:0] >= CUST_MIN && merged[12:0] <= CUST_MAX
                 && merged[31:13] == '0;
            if (ok) next_cust[p] = merged[12:0];
          end
          OFS_DELAY:
          begin
            merged = mergeBytes(32'(dly[p]), wdata, wstrb);
            ok = merged[11:0] <= MS_MAX && merged[31:12] == '0;
            if (ok) next_dly[p] = merged[11:0];
          end
          OFS_TMO:
          begin
            merged = mergeBytes(32'(tmo[p]), wdata, wstrb);
            ok = merged[11:0] <= MS_MAX && merged[31:12] == '0;
            if (ok) next_tmo[p] = merged[11:0];
          end
          default: ok = 1'b0;
        endcase
      end
      else if (ofs == OFS_STATUS)
      begin
        ok = 1'b1;
        merged = mergeBytes(32'h0, wdata, wstrb);
        next_status = (status & ~merged[ST_W-1:0]) | events;
      end
      else if (ofs == OFS_MASK)
      begin
        ok = 1'b1;
        merged = mergeBytes(32'(mask), wdata, wstrb);
        next_mask = merged[ST_W-1:0];
      end
      next_bresp = ok ? RESP_OK : RESP_ERR;
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
      begin
        cfg[i] <= CFG_RST;
        cust[i] <= CUST_RST;
        dly[i] <= DELAY_RST;
        tmo[i] <= TMO_RST;
      end
      status <= '0;
      mask <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OK;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      cfg <= next_cfg;
      cust <= next_cust;
      dly <= next_dly;
      tmo <= next_tmo;
      status <= next_status;
      mask <= next_mask;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      irq <= next_irq;
    end
  end

  // register reads
  always_comb
  begin
    logic [7:0] ofs;
    int         p;
    ofs = {araddr[7:2], 2'b00};
    p = int'(ofs[7:4]);
    next_rvalid = rvalid & ~rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rdGo)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OK;
      next_rdata = '0;
      if (ofs < OFS_STATUS)
      begin
        case ({4'h0, ofs[3:0]})
          OFS_CFG: next_rdata = 32'(cfg[p]);
          OFS_CUST: next_rdata = 32'(cust[p]);
          OFS_DELAY: next_rdata = 32'(dly[p]);
          OFS_TMO: next_rdata = 32'(tmo[p]);
          default: next_rresp = RESP_ERR;
        endcase
      end
      else if (ofs == OFS_STATUS) next_rdata = 32'(status);
      else if (ofs == OFS_MASK) next_rdata = 32'(mask);
      else if (ofs == OFS_STATE) next_rdata = {29'h0, runLevel, active};
      else next_rresp = RESP_ERR;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OK;
    end
    else if (ce)
    begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // bit-rate tick per port, reloaded at zero or when the count is at or above a new rate's divisor
  always_comb
  begin
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      div[i] = baudDiv(cfg[i].baudSel, cust[i]);
      next_tick[i] = 1'b0;
      next_baudCnt[i] = baudCnt[i] - 1'b1;
      if (baudCnt[i] == '0 || baudCnt[i] >= div[i])
      begin
        next_baudCnt[i] = div[i] - 1'b1;
        next_tick[i] = active[i];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_PORTS; i++) baudCnt[i] <= '0;
      tick <= '0;
    end
    else if (ce)
    begin
      baudCnt <= next_baudCnt;
      tick <= next_tick;
    end
  end

  // independent engine for each port
  for (genvar g = 0; g < NUM_PORTS; g++)
  begin : gPort
    serial_port_ctrl #(
      .MsCycles (MsCycles)
    ) uCtrl (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .ce        (ce),
      .cfg       (cfg[g]),
      .delayMs   (dly[g]),
      .tmoMs     (tmo[g]),
      .runLevel  (runLevel),
      .pin       (portIn[g]),
      .active    (active[g]),
      .accepted  (accepted[g]),
      .discarded (discarded[g]),
      .replyGo   (replyGo[g]),
      .rxTimeout (rxTimeout[g])
    );
    assign events[g*EV_W + EV_ACC] = accepted[g];
    assign events[g*EV_W + EV_DIS] = discarded[g];
    assign events[g*EV_W + EV_REPLY] = replyGo[g];
    assign events[g*EV_W + EV_TMO] = rxTimeout[g];
    assign portOut[g] = '{active[g], accepted[g], discarded[g], replyGo[g],
                          rxTimeout[g], tick[g]};
    assign portCfg[g] = cfg[g];
  end
endmodule

// [tb/modbus_port_monitor.sv]
// concurrent checks on the ports of the serial station configuration block
`timescale 1ns/1ps
module modbus_port_monitor
  import modbus_port_pkg::*;
#(
  parameter int MsCycles = MS_CYCLES
) (
  // clock and reset
  input wire logic                       clk_sys,
  input wire logic                       rst,
  input wire logic                       ce,
  // register bus
  input wire logic                       awvalid,
  input wire logic                       wvalid,
  input wire logic                       bvalid,
  input wire logic                       arvalid,
  input wire logic                       rvalid,
  input wire logic [31:0]                rdata,
  input wire logic [1:0]                 rresp,
  // port traffic and settings
  input wire modbus_port_pkg::port_in_t  portIn [NUM_PORTS],
  input wire modbus_port_pkg::port_out_t portOut [NUM_PORTS],
  input wire modbus_port_pkg::port_cfg_t portCfg [NUM_PORTS]
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // frame taken by a running slave port
  sequence s_take0;
    ce && portIn[0].frameValid && portOut[0].active && !portCfg[0].masterMode;
  endsequence
  sequence s_take1;
    ce && portIn[1].frameValid && portOut[1].active && !portCfg[1].masterMode;
  endsequence
  property p_hit;
    s_take0 ##0 portIn[0].frameAddr == portCfg[0].stationAddr
      |=> portOut[0].accepted && !portOut[0].discarded;
  endproperty
  a_hit: assert property (p_hit) else $error("own address frame not accepted");
  property p_bcast;
    s_take1 ##0 portIn[1].frameAddr == 8'h00 |=> portOut[1].accepted;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast frame not accepted");
  property p_miss;
    s_take0 ##0 (portIn[0].frameAddr != 8'h00 && portIn[0].frameAddr != portCfg[0].stationAddr)
      |=> portOut[0].discarded && !portOut[0].accepted;
  endproperty
  a_miss: assert property (p_miss) else $error("foreign frame not discarded");
  property p_port1;
    s_take1 ##0 portIn[1].frameAddr == portCfg[1].stationAddr |=> portOut[1].accepted;
  endproperty
  a_port1: assert property (p_port1) else $error("second port missed own frame");
  property p_idle;
    ce && portIn[0].frameValid && !portOut[0].active
      |=> !(portOut[0].accepted || portOut[0].discarded);
  endproperty
  a_idle: assert property (p_idle) else $error("stopped port reacted to a frame");
  property p_cfg;
    portCfg[0].stationAddr inside {[8'h01:8'hfe]} && portCfg[0].parity != 2'b11
      && portCfg[0].baudSel <= 4'h8;
  endproperty
  a_cfg: assert property (p_cfg) else $error("illegal setting held");
  property p_tick;
    !portOut[0].active ##1 !portOut[0].active |-> !portOut[0].baudTick;
  endproperty
  a_tick: assert property (p_tick) else $error("bit tick on stopped port");
  property p_wr;
    ce && awvalid && wvalid && !bvalid |=> bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write not answered");
  property p_rd;
    ce && arvalid && !rvalid |=> rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rerr;
    rvalid && rresp == 2'b10 |-> rdata == 32'h0;
  endproperty
  a_rerr: assert property (p_rerr) else $error("refused read returned data");
endmodule

bind modbus_serial_port_config modbus_port_monitor #(.MsCycles(MsCycles))
  modbus_port_monitor_i (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .awvalid(awvalid), .wvalid(wvalid),
  .bvalid(bvalid), .arvalid(arvalid), .rvalid(rvalid), .rdata(rdata), .rresp(rresp),
  .portIn(portIn), .portOut(portOut), .portCfg(portCfg)
);

// [tb/far_station_model.sv]
// far station on one serial port: frame, end, request and reply events
`timescale 1ns/1ps
module far_station_model
  import modbus_port_pkg::*;
(
  // clock
  input wire logic                  clk_sys,
  // events towards the port
  output modbus_port_pkg::port_in_t frm
);
  initial frm = '0;
  // k: 0 frame, 1 end, 2 request sent, 3 reply done
  task automatic pulse(input int k, input logic [7:0] a);
    frm.frameAddr <= a;
    frm.frameValid <= (k == 0);
    frm.frameEnd <= (k == 1);
    frm.reqSent <= (k == 2);
    frm.replyDone <= (k == 3);
    @(posedge clk_sys);
    // released address lines do not keep the last value
    frm <= {1'b0, ~a, 3'b000};
    @(posedge clk_sys);
  endtask
endmodule

// [tb/test_modbus_serial_port_config.sv]
// self-checking bench of the two-port serial station configuration block
`timescale 1ns/1ps
`define CHK(nm, e, s) \
  begin \
    comparisons++; \
    if ((s) !== (e)) \
    begin \
      fails++; \
      $display("MISMATCH %s exp %h got %h", nm, e, s); \
    end \
  end
module test_modbus_serial_port_config;
  import modbus_port_pkg::*;
  localparam int MS = 4;
  logic        clk_sys;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [2:0]  awprot = 3'h0;
  logic [2:0]  arprot = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [3:0]  strb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        bready = 1'b1;
  logic        rready = 1'b1;
  logic        runPin = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  port_in_t    portIn [NUM_PORTS];
  port_out_t   portOut [NUM_PORTS];
  port_cfg_t   portCfg [NUM_PORTS];
  logic [31:0] mdl [int];
  logic [7:0]  a0, a1;
  logic [7:0]  fa [6];
  int          fails = 0;
  int          comparisons = 0;
  int          n, cyc = 0, tEnd = 0, tGo = 0, tReq = 0, tTmo = 0, tTick = 0, tPrev = 0;
  int          dv [5] = '{1302, 651, 434, 217, 100};
  int          fp [6] = '{0, 0, 0, 1, 1, 1};
  logic [31:0] fs [6] = '{32'h1, 32'h1, 32'h2, 32'h10, 32'h20, 32'h10};
  logic [7:0]  ta [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h14, 8'h14,
                           8'h08, 8'h08, 8'h1c, 8'h1c};
  logic [31:0] td [12] = '{32'h4300, 32'h43ff, 32'h43fe, 32'h6301, 32'h4901, 32'h0,
                           32'h1389, 32'h1388, 32'hbb9, 32'hbb8, 32'hbb9, 32'h0};

  modbus_serial_port_config #(.MsCycles(MS)) modbus_serial_port_config_i (
    .clk_sys(clk_sys), .rst(rst), .ce(ce),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .runPin(runPin), .portIn(portIn), .portOut(portOut), .portCfg(portCfg), .irq(irq)
  );
  far_station_model stn0 (.clk_sys(clk_sys), .frm(portIn[0]));
  far_station_model stn1 (.clk_sys(clk_sys), .frm(portIn[1]));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // event time stamps, sampled where the design samples them
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (portIn[0].frameEnd) tEnd <= cyc;
    if (portOut[0].replyGo) tGo <= cyc;
    if (portIn[1].reqSent) tReq <= cyc;
    if (portOut[1].rxTimeout) tTmo <= cyc;
    if (portOut[0].baudTick)
    begin
      tPrev <= tTick;
      tTick <= cyc;
    end
  end

  task automatic conclude();
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // write through the bus; model predicts response and new contents
  task automatic wc(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] m;
    logic        ok;
    m = mdl.exists(a) ? mdl[a] : 32'h0;
    for (int i = 0; i < 4; i++)
      if (strb[i]) m[8*i +: 8] = d[8*i +: 8];
    case (a)
      8'h00, 8'h10: ok = m[7:0] inside {[8'h01:8'hfe]} && m[11:8] <= 4'h8 && m[14:13] != 2'h3;
      8'h04, 8'h14: ok = m inside {[32'h1:32'h1388]};
      8'h08, 8'h18, 8'h0c, 8'h1c: ok = m <= 32'hbb8;
      8'h20, 8'h24: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    if (a == 8'h20) m = mdl[a] & ~d;
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk_sys); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk_sys); while (!bvalid);
    `CHK("bresp", ok ? 2'b00 : 2'b10, bresp)
    if (ok) mdl[a] = m;
  endtask

  task automatic rc(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    `CHK("rresp", mdl.exists(a) ? 2'b00 : 2'b10, rresp)
    `CHK("rdata", mdl.exists(a) ? mdl[a] : 32'h0, rdata)
  endtask

  task automatic ev(input int p, input int k, input logic [7:0] a);
    if (p == 0) stn0.pulse(k, a);
    else stn1.pulse(k, a);
    repeat (2) @(posedge clk_sys);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end

  initial
  begin
    void'($urandom(63));
    for (int p = 0; p < 32; p += 16)
    begin
      mdl[p] = 32'h4301;
      mdl[p + 4] = 32'h60;
      mdl[p + 8] = 32'h0;
      mdl[p + 12] = 32'hc8;
    end
    mdl[32] = 32'h0;
    mdl[36] = 32'h0;
    mdl[40] = 32'h0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (mdl[a]) rc(8'(a));
    rc(8'h2c);
    foreach (ta[i])
    begin
      wc(ta[i], td[i]);
      rc(ta[i]);
    end
    strb = 4'h1;
    wc(8'h14, 32'hffffff10);
    strb = 4'hf;
    rc(8'h14);
    // distinct random station addresses for the two ports
    a0 = 8'(1 + $urandom % 254);
    a1 = a0 % 8'hfe + 8'h01;
    fa = '{a0, 8'h00, a1, 8'h00, a0, a1};
    wc(8'h00, {16'h0, 8'h43, a0});
    wc(8'h10, {8'h0, 8'h04, 8'h43, a1});
    mdl[40] = 32'h2;
    rc(8'h28);
    ev(0, 0, a0);
    rc(8'h20);
    runPin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    mdl[40] = 32'h7;
    rc(8'h28);
    wc(8'h24, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      ev(fp[i], 0, fa[i]);
      mdl[32] = fs[i];
      rc(8'h20);
      `CHK("irq", fs[i][0], irq)
      wc(8'h20, fs[i]);
    end
    @(posedge clk_sys);
    `CHK("irq", 1'b0, irq)
    for (int d = 0; d < 4; d += 3)
    begin
      wc(8'h08, 32'(d));
      ev(0, 0, a0);
      ev(0, 1, a0);
      repeat (20) @(posedge clk_sys);
      // registered pulse is seen one edge after it rises
      `CHK("replyDelay", d * MS + 2, tGo - tEnd)
      wc(8'h20, 32'hff);
    end
    n = tGo;
    ev(0, 0, 8'h00);
    ev(0, 1, 8'h00);
    repeat (20) @(posedge clk_sys);
    `CHK("broadcastReply", n, tGo)
    wc(8'h10, {8'h0, 8'h06, 8'h43, a1});
    wc(8'h1c, 32'h2);
    ev(1, 2, 8'h00);
    repeat (20) @(posedge clk_sys);
    `CHK("rxTimeout", 2 * MS + 1, tTmo - tReq)
    n = tTmo;
    ev(1, 2, 8'h00);
    ev(1, 3, 8'h00);
    repeat (20) @(posedge clk_sys);
    `CHK("replyInTime", n, tTmo)
    wc(8'h00, 32'h1b300 | a0);
    @(posedge clk_sys);
    `CHK("portCfg", port_cfg_t'(19'h1b300 | a0), portCfg[0])
    wc(8'h04, 32'h9c4);
    for (int s = 4; s <= 8; s++)
    begin
      wc(8'h00, 32'(32'h1b000 | (s << 8) | a0));
      repeat (3 * dv[s - 4]) @(posedge clk_sys);
      `CHK("bitTime", dv[s - 4], tTick - tPrev)
    end
    conclude();
  end
endmodule
